/* File: logic/dcfg_defs.vh */
// Behaviour
// [R1] Writing general config bit 6 low enables back-channel check generation; high, the reset value, disables it.
// [R2] General config bit 5 picks the weak pull on undriven inputs: 1 pull-down (reset), 0 pull-up.
// [R3] With bit 4 set (reset), pulses on valid, hsync or vsync shorter than two pixel clocks are rejected.
// [R4] With bit 3 set, a serial-bus transaction whose address decode matches is forwarded to the remote end.
// [R5] With bit 2 set, serial-bus writes are acknowledged automatically whatever the lock state.
// [R6] Pixel data is gated by valid always with a protected peer, otherwise only when bit 1 is set.
// [R7] The watchdog ends a control-channel transaction that outlives the programmed timeout.
// [R8] The seven-bit timeout field counts in 2 ms steps and resets to 0x7F.
// [R9] Software should never program the timeout field to zero.
// [R10] Watchdog control bit 0 high disables the watchdog; it resets low so the watchdog runs.
// [R11] Serial-bus control 1 bit 7 set passes every transaction to the remote side.
// [R12] The three-bit hold field sets internal SDA hold after SCL in 50 ns steps, reset 0x1.
// [R13] The four-bit filter field sets the widest rejected SCL/SDA glitch in 5 ns steps, reset 0xE.
// [R14] Software writes reserved bits with their reset values and relies on them for nothing.
`ifndef DCFG_DEFS_VH
`define DCFG_DEFS_VH
`define DCFG_ADDR_GEN       8'h03
`define DCFG_ADDR_WDOG      8'h04
`define DCFG_ADDR_SBUS      8'h05
`define DCFG_RST_GEN        8'hF0
`define DCFG_RST_WDOG       8'hFE
`define DCFG_RST_SBUS       8'h1E
`define DCFG_BIT_CHK        6
`define DCFG_BIT_PULL       5
`define DCFG_BIT_FILT       4
`define DCFG_BIT_PASS       3
`define DCFG_BIT_AACK       2
`define DCFG_BIT_GATE       1
`define DCFG_BIT_WOFF       0
`define DCFG_BIT_PALL       7
`define DCFG_FLD_TMO        7:1
`define DCFG_FLD_HOLD       6:4
`define DCFG_FLD_FILT       3:0
`define DCFG_CLK_KHZ        250000
`define DCFG_STEP_MS        2
`define DCFG_HOLD_STEP_NS   50
`define DCFG_FILT_STEP_NS   5
`endif

/* File: logic/dcfg_regs.v */
`timescale 1ns/1ns
`include "dcfg_defs.vh"
module dcfg_regs #(
   parameter STEP_CYCLES = `DCFG_CLK_KHZ * `DCFG_STEP_MS
) (
   input  wire       core_clk_i,
   input  wire       rst_n_i,
   // Local register access
   input  wire       reg_wr_i,
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   output reg  [7:0] reg_rdata_o,
   // Outside levels, synchronised below
   input  wire       peer_protected_i,
   input  wire       valid_in_i,
   input  wire       hsync_in_i,
   input  wire       vsync_in_i,
   input  wire       txn_active_i,
   input  wire       addr_match_i,
   // Filtered sync lanes, static controls and the watchdog abort pulse
   output wire       valid_out_o,
   output wire       hsync_out_o,
   output wire       vsync_out_o,
   output wire       pixel_gate_o,
   output wire       backchannel_check_gen_en_o,
   output wire       undriven_input_pull_select_o,
   output wire       forward_txn_o,
   output wire       auto_ack_o,
   output reg        txn_abort_o,
   output wire [2:0] sda_hold_steps_o,
   output wire [3:0] glitch_filter_steps_o
);
   // ****************************************
   // Register file
   // ****************************************
   reg  [7:0]  gen_cfg;
   reg  [7:0]  wdog_cfg;
   reg  [7:0]  sbus_cfg;
   reg  [5:0]  pin_s1;
   reg  [5:0]  pin_s2;

   // Bit positions inside the synchroniser word
   localparam  PIN_VALID = 0;
   localparam  PIN_HSYNC = 1;
   localparam  PIN_VSYNC = 2;
   localparam  PIN_PROT  = 3;
   localparam  PIN_MATCH = 4;
   localparam  PIN_TXN   = 5;
   localparam  SYNC_CH   = 3;   // Valid, hsync and vsync lanes

   // Writes at documented offsets, all bits stored
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         gen_cfg  <= `DCFG_RST_GEN;
         wdog_cfg <= `DCFG_RST_WDOG;
         sbus_cfg <= `DCFG_RST_SBUS;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `DCFG_ADDR_GEN)  gen_cfg  <= reg_wdata_i;
         if (reg_addr_i == `DCFG_ADDR_WDOG) wdog_cfg <= reg_wdata_i;
         if (reg_addr_i == `DCFG_ADDR_SBUS) sbus_cfg <= reg_wdata_i;
      end
   end

   // Read data registered; unmapped reads zero
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         case (reg_addr_i)
            `DCFG_ADDR_GEN:  reg_rdata_o <= gen_cfg;
            `DCFG_ADDR_WDOG: reg_rdata_o <= wdog_cfg;
            `DCFG_ADDR_SBUS: reg_rdata_o <= sbus_cfg;
            default:         reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Static controls
   // ****************************************
   // Named views of the stored configuration bits
   wire        chk_gen_off   = gen_cfg[`DCFG_BIT_CHK];
   wire        pull_down_sel = gen_cfg[`DCFG_BIT_PULL];
   wire        filt_on       = gen_cfg[`DCFG_BIT_FILT];
   wire        pass_match    = gen_cfg[`DCFG_BIT_PASS];
   wire        auto_ack_on   = gen_cfg[`DCFG_BIT_AACK];
   wire        gate_on       = gen_cfg[`DCFG_BIT_GATE];
   wire        wdog_off      = wdog_cfg[`DCFG_BIT_WOFF];
   wire [6:0]  wdog_limit    = wdog_cfg[`DCFG_FLD_TMO];
   wire        pass_all      = sbus_cfg[`DCFG_BIT_PALL];
   wire [2:0]  hold_field    = sbus_cfg[`DCFG_FLD_HOLD];
   wire [3:0]  filt_field    = sbus_cfg[`DCFG_FLD_FILT];

   // Synchronised outside levels
   wire        peer_prot_s   = pin_s2[PIN_PROT];
   wire        addr_match_s  = pin_s2[PIN_MATCH];
   wire        txn_active_s  = pin_s2[PIN_TXN];

   // Inverted sense: a stored one turns the check generator off
   assign backchannel_check_gen_en_o   = ~chk_gen_off;   // [R1]
   assign undriven_input_pull_select_o = pull_down_sel;  // [R2]
   assign auto_ack_o                   = auto_ack_on;    // [R5]

   // Pass-all overrides the decode-qualified forward
   assign forward_txn_o = pass_all |                     // [R11]
                          (pass_match & addr_match_s);   // [R4]

   // A protected peer forces gating whatever the bit says
   assign pixel_gate_o  = peer_prot_s | gate_on;         // [R6]

   // Step counts only; the pad timing lives elsewhere
   assign sda_hold_steps_o      = hold_field;  // [R12] 50 ns per step
   assign glitch_filter_steps_o = filt_field;  // [R13] 5 ns per step

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Two stages on every outside input
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pin_s1 <= 6'h00;
         pin_s2 <= 6'h00;
      end else begin
         pin_s1 <= {txn_active_i, addr_match_i, peer_protected_i,
                    vsync_in_i, hsync_in_i, valid_in_i};
         pin_s2 <= pin_s1;
      end
   end

   // ****************************************
   // Two-clock sync filter
   // ****************************************
   wire [SYNC_CH-1:0] filt_out;
   genvar             ch;

   // One identical filter per sync lane
   generate
      for (ch = 0; ch < SYNC_CH; ch = ch + 1) begin : g_filt
         reg prev_lvl;
         reg out_lvl;

         // With the filter on, output follows only a level seen on two edges
         always @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               prev_lvl <= 1'b0;
               out_lvl  <= 1'b0;
            end else begin
               prev_lvl <= pin_s2[ch];
               if (!filt_on) begin
                  out_lvl <= pin_s2[ch];
               end else if (pin_s2[ch] == prev_lvl) begin
                  out_lvl <= pin_s2[ch]; // [R3]
               end
            end
         end
         assign filt_out[ch] = out_lvl;
      end
   endgenerate

   // Lane order follows the synchroniser word
   assign valid_out_o = filt_out[PIN_VALID];
   assign hsync_out_o = filt_out[PIN_HSYNC];
   assign vsync_out_o = filt_out[PIN_VSYNC];

   // ****************************************
   // Control-channel watchdog
   // ****************************************
   reg  [31:0] step_cnt;
   reg  [6:0]  tick_cnt;
   reg  [31:0] next_step_cnt;
   reg  [6:0]  next_tick_cnt;
   reg         next_abort;

   // Runs only while a transaction is open and not disabled
   wire        wdog_run  = txn_active_s & ~wdog_off;          // [R10]
   wire        step_end  = (step_cnt == STEP_CYCLES - 1);
   // A zero limit behaves like one step
   wire        last_tick = (tick_cnt + 7'h01 >= wdog_limit);  // [R8]

   // Next-state of the step and tick counters
   always @* begin
      next_step_cnt = step_cnt + 32'h00000001;
      next_tick_cnt = tick_cnt;
      next_abort    = 1'b0;
      if (!wdog_run) begin
         // Idle or disabled: hold both counters cleared
         next_step_cnt = 32'h00000000;
         next_tick_cnt = 7'h00;
      end else if (step_end) begin
         next_step_cnt = 32'h00000000;
         if (last_tick) begin
            next_abort    = 1'b1; // [R7]
            next_tick_cnt = 7'h00;
         end else begin
            next_tick_cnt = tick_cnt + 7'h01;
         end
      end
   end

   // Counter registers and the one-cycle abort pulse
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         step_cnt    <= 32'h00000000;
         tick_cnt    <= 7'h00;
         txn_abort_o <= 1'b0;
      end else begin
         step_cnt    <= next_step_cnt;
         tick_cnt    <= next_tick_cnt;
         txn_abort_o <= next_abort;
      end
   end
endmodule // dcfg_regs

/* File: tb/dcfg_peer.sv */
`timescale 1ns/1ns
module dcfg_peer(
   input  wire logic clk_i,
   input  wire logic go_i,
   input  wire logic match_i,
   input  wire logic prot_i,
   output wire logic txn_o,
   output wire logic match_o,
   output wire logic prot_o);
   int n = 0;
   // Slow serializer: holds the channel transaction open 50 cycles
   always @(posedge clk_i) n <= go_i ? 50 : (n > 0 ? n - 1 : 0);
   assign txn_o = n > 0;
   assign match_o = match_i;
   assign prot_o = prot_i;
endmodule // dcfg_peer

/* File: tb/dcfg_chk.sv */
`timescale 1ns/1ns
module dcfg_chk(
   input wire logic core_clk_i, rst_n_i, reg_wr_i, txn_abort_o, auto_ack_o, forward_txn_o,
   input wire logic backchannel_check_gen_en_o, undriven_input_pull_select_o,
   input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   input wire logic [2:0] sda_hold_steps_o,
   input wire logic [3:0] glitch_filter_steps_o);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] wq;
   wire wg = reg_wr_i && reg_addr_i == 8'h03;
   wire ws = reg_wr_i && reg_addr_i == 8'h05;
   // Write data one cycle back
   always @(posedge core_clk_i) wq <= reg_wdata_i;
   check_gen_a: assert property (wg |=> backchannel_check_gen_en_o != wq[6]) else $error("gen");
   pull_sel_a: assert property (wg |=> undriven_input_pull_select_o == wq[5]) else $error("pull");
   auto_ack_a: assert property (wg |=> auto_ack_o == wq[2]) else $error("ack");
   pass_all_a: assert property (ws && reg_wdata_i[7] |=> forward_txn_o) else $error("fwd");
   hold_field_a: assert property (ws |=> sda_hold_steps_o == wq[6:4]) else $error("hold");
   filter_field_a: assert property (ws |=> glitch_filter_steps_o == wq[3:0]) else $error("flt");
   unmapped_read_a: assert property (reg_addr_i > 8'h05 |=> reg_rdata_o == 8'h00) else $error("rd");
   abort_pulse_a: assert property (txn_abort_o |=> !txn_abort_o) else $error("abort");
   reset_values_a: assert property ($rose(rst_n_i) |-> !backchannel_check_gen_en_o && !auto_ack_o
      && sda_hold_steps_o == 3'h1 && glitch_filter_steps_o == 4'hE) else $error("rst");
   cover property (wg);
   cover property (txn_abort_o);
   cover property (ws && reg_wdata_i[7]);
endmodule // dcfg_chk

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
   logic core_clk_i=0, rst_n_i=0, reg_wr_i=0, valid_in_i=0, go=0, am=0, pp=0;
   logic [7:0] reg_addr_i=0, reg_wdata_i=0, reg_rdata_o, gen=8'hF0, sb=8'h1E;
   wire peer_protected_i, txn_active_i, addr_match_i, valid_out_o, hsync_out_o, vsync_out_o;
   wire hsync_in_i = valid_in_i;
   wire vsync_in_i = valid_in_i;
   wire pixel_gate_o, backchannel_check_gen_en_o, undriven_input_pull_select_o;
   wire forward_txn_o, auto_ack_o, txn_abort_o;
   wire [2:0] sda_hold_steps_o;
   wire [3:0] glitch_filter_steps_o;
   wire [11:0] ctl = {pixel_gate_o, backchannel_check_gen_en_o, undriven_input_pull_select_o,
      forward_txn_o, auto_ack_o, sda_hold_steps_o, glitch_filter_steps_o};
   int mismatches=0, checks_done=0, cyc=0, i;
   dcfg_regs #(.STEP_CYCLES(4)) i_dut(.*);
   dcfg_peer i_peer(.clk_i(core_clk_i), .go_i(go), .match_i(am), .prot_i(pp),
      .txn_o(txn_active_i), .match_o(addr_match_i), .prot_o(peer_protected_i));
   always #2 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (++cyc == 5000) begin mismatches++; tally_and_finish; end
   function logic [11:0] ex();
      return {pp | gen[1], ~gen[6], gen[5], sb[7] | (gen[3] & am), gen[2], sb[6:0]};
   endfunction
   task chk(input logic [11:0] g, e);
      checks_done++;
      if (g !== e) begin mismatches++; $display("Error %0t: got %h exp %h", $time, g, e); end
   endtask
   task wrt(input logic [7:0] a, d);
      @(posedge core_clk_i) #1 reg_wr_i=1; reg_addr_i=a; reg_wdata_i=d;
      @(posedge core_clk_i) #1 reg_wr_i=0;
   endtask
   task rdc(input logic [7:0] a, e);
      @(posedge core_clk_i) #1 reg_addr_i=a;
      @(posedge core_clk_i) #1 chk(reg_rdata_o, e);
   endtask
   task pulse(input int n, input logic e);
      logic [2:0] s;
      s=0;
      @(posedge core_clk_i) #1 valid_in_i=1;
      repeat(n) @(posedge core_clk_i);
      #1 valid_in_i=0;
      repeat(7) begin @(posedge core_clk_i) #1 s |= {valid_out_o, hsync_out_o, vsync_out_o}; end
      chk(s, {3{e}});
   endtask
   task wdog(input logic [7:0] v, input logic e);
      int t;
      t=0;
      wrt(8'h04, v);
      rdc(8'h04, v);
      @(posedge core_clk_i) #1 go=1;
      @(posedge core_clk_i) #1 go=0;
      while (txn_abort_o !== 1 && t < 40) begin @(posedge core_clk_i) #1 t++; end
      chk(t > 5 && t < 16, e);
      repeat(60) @(posedge core_clk_i);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      i = $urandom(19);
      repeat(16) @(posedge core_clk_i);
      #1 rst_n_i=1;
      rdc(8'h03, gen); rdc(8'h04, 8'hFE); rdc(8'h05, sb); rdc(8'h06, 0);
      chk(ctl, ex());
      for (i=0; i<12; i++) begin
         gen=$urandom; sb=$urandom; am=$urandom; pp=$urandom;
         gen[7]=1'b1; gen[0]=1'b0;
         wrt(8'h03, gen); wrt(8'h05, sb); wrt(8'h02, 8'h5A);
         rdc(8'h03, gen); rdc(8'h05, sb); rdc(8'h02, 0);
         chk(ctl, ex());
      end
      $display("register test done");
      wrt(8'h03, 8'hF0); pulse(1, 0); pulse(3, 1); wrt(8'h03, 8'hE0); pulse(1, 1);
      $display("filter test done");
      wdog(8'h04, 1); wdog(8'h05, 0);
      $display("watchdog test done");
      tally_and_finish;
   end
endmodule // tb
bind dcfg_regs dcfg_chk i_chk(.*);
